// ==== hdl/rcpm_regs.svh ====
// register addresses, field positions, reset values and counts for the reset/clock/power manager
`ifndef RCPM_REGS_SVH
`define RCPM_REGS_SVH

// ----------------------------------------------------------------
// register byte addresses
// ----------------------------------------------------------------
`define RCPM_ADDR_FLAGS       32'hffff0230
`define RCPM_ADDR_CLEAR       32'hffff0234
`define RCPM_ADDR_PKEY1       32'hffff0404
`define RCPM_ADDR_PCTRL       32'hffff0408
`define RCPM_ADDR_PKEY2       32'hffff040c
`define RCPM_ADDR_CKEY1       32'hffff0410
`define RCPM_ADDR_CSEL        32'hffff0414
`define RCPM_ADDR_CKEY2       32'hffff0418

// ----------------------------------------------------------------
// unlock key values
// ----------------------------------------------------------------
`define RCPM_PKEY1_VAL        8'h01
`define RCPM_PKEY2_VAL        8'hf4
`define RCPM_CKEY1_VAL        8'haa
`define RCPM_CKEY2_VAL        8'h55

// ----------------------------------------------------------------
// field positions
// ----------------------------------------------------------------
`define RCPM_FLAG_POR         0
`define RCPM_FLAG_WDT         1
`define RCPM_FLAG_SW          2
`define RCPM_FLAG_EXT         3
`define RCPM_PC_CORE          3
`define RCPM_PC_PERIPH        4
`define RCPM_PC_PLL           5
`define RCPM_PC_XTAL          6
`define RCPM_CSEL_EXTERNAL    2'h2

// ----------------------------------------------------------------
// reset values and counts
// ----------------------------------------------------------------
`define RCPM_FLAGS_POR_VAL    4'h1
`define RCPM_PC_RESET         8'h7b
`define RCPM_PC_WAKE_MASK     8'h38
`define RCPM_PC_WR_MASK       8'h7f
`define RCPM_CSEL_RESET       2'h0
`define RCPM_RST_HOLD         8'h10

`endif

// ==== hdl/rcpm_pkg.sv ====
// types shared by the reset/clock/power manager
package rcpm_pkg;

    // unlock sequence tracker states
    typedef enum logic [2:0] {
        KS_IDLE = 3'h1,
        KS_KEY1 = 3'h2,
        KS_HELD = 3'h4
    } rcpm_key_state_t;

    // power mode codes, {xtal, pll, periph, core}
    typedef enum logic [3:0] {
        PM_ACTIVE = 4'hf,
        PM_PAUSE  = 4'he,
        PM_NAP    = 4'hc,
        PM_SLEEP  = 4'h8,
        PM_STOP   = 4'h0
    } rcpm_pmode_t;

endpackage

// ==== hdl/rcpm_core_div.sv ====
// binary divider of the pll system clock strobe
`timescale 1ns/1ps
module rcpm_core_div import rcpm_pkg::*; (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic srst,
    // divider
    input wire logic tick_in,
    input wire logic [2:0] div_sel,
    output logic tick_out
);
    logic [6:0] cnt_reg;
    logic [6:0] cnt_next;
    wire [6:0] mask = 7'((8'h01 << div_sel) - 8'h01);
    wire wrap = tick_in & ((cnt_reg & mask) == mask);

    assign cnt_next = srst ? 7'h00 : (wrap ? 7'h00 : (tick_in ? 7'(cnt_reg + 7'h01) : cnt_reg));

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            cnt_reg <= 7'h00;
            tick_out <= 1'b0;
        end else begin
            cnt_reg <= cnt_next;
            tick_out <= wrap & ~srst;
        end
    end
endmodule // rcpm_core_div

// ==== hdl/rcpm_key_seq.sv ====
// key-protected write sequencer: key1, target write, key2
`timescale 1ns/1ps
module rcpm_key_seq import rcpm_pkg::*; #(
    parameter logic [31:0] KEY1_ADDR = 32'h0,
    parameter logic [31:0] TARGET_ADDR = 32'h4,
    parameter logic [31:0] KEY2_ADDR = 32'h8,
    parameter logic [7:0] KEY1_VAL = 8'h00,
    parameter logic [7:0] KEY2_VAL = 8'h00
) (
    // clock and reset
    input wire logic clock,
    input wire logic rst_n,
    input wire logic srst,
    // completed bus writes
    input wire logic wr_en,
    input wire logic [31:0] wr_addr,
    input wire logic [7:0] wr_data,
    // accepted update
    output logic commit,
    output logic [7:0] commit_data
);
    rcpm_key_state_t state_reg;
    rcpm_key_state_t state_next;
    logic [7:0] held_reg;
    wire key1_ok = wr_en & (wr_addr == KEY1_ADDR) & (wr_data == KEY1_VAL);
    wire tgt_wr = wr_en & (wr_addr == TARGET_ADDR);
    wire key2_ok = wr_en & (wr_addr == KEY2_ADDR) & (wr_data == KEY2_VAL);

    // any other write in between breaks the sequence; a correct key1 write starts it over
    always_comb begin
        state_next = state_reg;
        case (state_reg)
            KS_IDLE: if (key1_ok) state_next = KS_KEY1;
            KS_KEY1: if (wr_en) state_next = tgt_wr ? KS_HELD : (key1_ok ? KS_KEY1 : KS_IDLE);
            KS_HELD: if (wr_en) state_next = key1_ok ? KS_KEY1 : KS_IDLE;
            default: state_next = KS_IDLE;
        endcase
        if (srst) state_next = KS_IDLE;
    end

    always_ff @(posedge clock or negedge rst_n) begin
        if (!rst_n) begin
            state_reg <= KS_IDLE;
            held_reg <= 8'h00;
            commit <= 1'b0;
            commit_data <= 8'h00;
        end else begin
            state_reg <= state_next;
            if (state_reg == KS_KEY1 && tgt_wr) held_reg <= wr_data;
            commit <= ~srst & (state_reg == KS_HELD) & key2_ok;
            commit_data <= held_reg;
        end
    end
endmodule // rcpm_key_seq

// ==== hdl/rcpm_top.sv ====
// reset source tracking, core clock divider and power mode control with apb registers
//
// Behaviour
// - power-on reset sets flag bit 0
// - watchdog timeout sets flag bit 1
// - external reset pin sets flag bit 3
// - writing flag bit 2 causes software reset
// - write-only clear register clears matching flags
// - flag bits 7 to 4 read zero
// - clear write keeping software flag resets again
// - all resets restore power and clock select registers; flags and watchdog only on por
// - system clock from pll at 10.24 MHz
// - core clock is system clock over 2^divider
// - divider field resets to 3
// - clock source select picks pll reference
// - power control needs key before and after
// - control bits 6 to 3 select mode
// - modes gate domains cumulatively, interrupts stay
// - wake-up sets core, peripheral, pll enables
`timescale 1ns/1ps
`include "rcpm_regs.svh"
module rcpm_top import rcpm_pkg::*; (
    // clock and reset
    input wire logic clock,
    input wire logic rstn,
    // apb slave
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] paddr,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    // reset sources and wake-up
    input wire logic wdt_timeout,
    input wire logic ext_reset_n,
    input wire logic wake_event,
    // pll system clock edge strobe
    input wire logic pll_system_clock_tick,
    // reset outputs
    output logic sys_reset_n,
    output logic wdt_reset_n,
    output logic boot_kernel_start,
    // clock and power outputs
    output logic core_clock_tick,
    output logic core_enable,
    output logic periph_enable,
    output logic pll_enable,
    output logic xtal_enable,
    output logic pll_ref_external,
    output logic ext_irq_enable,
    output logic [3:0] power_mode
);

    // ----------------------------------------------------------------
    // reset synchroniser
    // ----------------------------------------------------------------
    logic [1:0] rst_pipe_reg;
    wire rst_sync_n = rst_pipe_reg[1];

    always_ff @(posedge clock or negedge rstn) begin
        if (!rstn) rst_pipe_reg <= 2'b00;
        else rst_pipe_reg <= {rst_pipe_reg[0], 1'b1};
    end

    // ----------------------------------------------------------------
    // apb decode
    // ----------------------------------------------------------------
    logic [3:0] flags_reg;
    logic [3:0] flags_next;
    logic [7:0] pc_reg;
    logic [7:0] pc_next;
    logic [1:0] csel_reg;
    logic [1:0] csel_next;

    wire setup_phase = psel & ~penable;
    wire wr_commit = psel & penable & pready & pwrite;
    wire sel_flags = (paddr == `RCPM_ADDR_FLAGS);
    wire sel_clear = (paddr == `RCPM_ADDR_CLEAR);
    wire sel_pctrl = (paddr == `RCPM_ADDR_PCTRL);
    wire sel_csel = (paddr == `RCPM_ADDR_CSEL);
    wire sel_keys = (paddr == `RCPM_ADDR_PKEY1) | (paddr == `RCPM_ADDR_PKEY2)
                  | (paddr == `RCPM_ADDR_CKEY1) | (paddr == `RCPM_ADDR_CKEY2);
    wire addr_hit = sel_flags | sel_clear | sel_pctrl | sel_csel | sel_keys;
    // write-only registers read back as zero
    wire [31:0] rd_mux = sel_flags ? {28'h0000000, flags_reg}
                       : sel_pctrl ? {24'h000000, pc_reg}
                       : sel_csel ? {30'h0, csel_reg}
                       : 32'h00000000;

    // zero-wait answer: pready registered from the setup phase
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pready <= 1'b0;
            prdata <= 32'h00000000;
            pslverr <= 1'b0;
        end else begin
            pready <= setup_phase;
            prdata <= (setup_phase & ~pwrite) ? rd_mux : 32'h00000000;
            pslverr <= setup_phase & ~addr_hit;
        end
    end

    // ----------------------------------------------------------------
    // reset source flags
    // ----------------------------------------------------------------
    wire flags_wr = wr_commit & sel_flags;
    wire clear_wr = wr_commit & sel_clear;
    wire sw_req = (flags_wr & pwdata[`RCPM_FLAG_SW])
                | (clear_wr & flags_reg[`RCPM_FLAG_SW] & ~pwdata[`RCPM_FLAG_SW]);
    wire [3:0] flag_set = {~ext_reset_n, sw_req, wdt_timeout, 1'b0};
    wire [3:0] flag_clr = clear_wr ? pwdata[3:0] : 4'h0;

    // set wins over a clear in the same cycle
    assign flags_next = (flags_reg & ~flag_clr) | flag_set;

    // only the power-on reset touches the flags
    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) flags_reg <= `RCPM_FLAGS_POR_VAL;
        else flags_reg <= flags_next;
    end

    // ----------------------------------------------------------------
    // reset generator
    // ----------------------------------------------------------------
    logic [7:0] hold_cnt_reg;
    logic [7:0] hold_cnt_next;
    wire hw_req = wdt_timeout | ~ext_reset_n | sw_req;
    wire sys_reset_n_next = (hold_cnt_next == 8'h00);
    wire srst = ~sys_reset_n;

    assign hold_cnt_next = hw_req ? `RCPM_RST_HOLD
                         : (hold_cnt_reg != 8'h00) ? 8'(hold_cnt_reg - 8'h01) : 8'h00;

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            hold_cnt_reg <= `RCPM_RST_HOLD;
            sys_reset_n <= 1'b0;
            boot_kernel_start <= 1'b0;
            wdt_reset_n <= 1'b0;
        end else begin
            hold_cnt_reg <= hold_cnt_next;
            sys_reset_n <= sys_reset_n_next;
            boot_kernel_start <= sys_reset_n_next & ~sys_reset_n;
            wdt_reset_n <= 1'b1;
        end
    end

    // ----------------------------------------------------------------
    // key-protected power control and clock source select
    // ----------------------------------------------------------------
    logic pow_commit;
    logic [7:0] pow_data;
    logic csel_commit;
    logic [7:0] csel_data;

    rcpm_key_seq #(
        .KEY1_ADDR(`RCPM_ADDR_PKEY1),
        .TARGET_ADDR(`RCPM_ADDR_PCTRL),
        .KEY2_ADDR(`RCPM_ADDR_PKEY2),
        .KEY1_VAL(`RCPM_PKEY1_VAL),
        .KEY2_VAL(`RCPM_PKEY2_VAL)
    ) u_pow_keys (
        .clock(clock),
        .rst_n(rst_sync_n),
        .srst(srst),
        .wr_en(wr_commit),
        .wr_addr(paddr),
        .wr_data(pwdata[7:0]),
        .commit(pow_commit),
        .commit_data(pow_data)
    );

    rcpm_key_seq #(
        .KEY1_ADDR(`RCPM_ADDR_CKEY1),
        .TARGET_ADDR(`RCPM_ADDR_CSEL),
        .KEY2_ADDR(`RCPM_ADDR_CKEY2),
        .KEY1_VAL(`RCPM_CKEY1_VAL),
        .KEY2_VAL(`RCPM_CKEY2_VAL)
    ) u_csel_keys (
        .clock(clock),
        .rst_n(rst_sync_n),
        .srst(srst),
        .wr_en(wr_commit),
        .wr_addr(paddr),
        .wr_data(pwdata[7:0]),
        .commit(csel_commit),
        .commit_data(csel_data)
    );

    // wake-up is or-ed in last so it beats a commit in the same cycle
    wire [7:0] pc_upd = pow_commit ? (pow_data & `RCPM_PC_WR_MASK) : pc_reg;
    wire [7:0] pc_wake = wake_event ? `RCPM_PC_WAKE_MASK : 8'h00;

    assign pc_next = srst ? `RCPM_PC_RESET : (pc_upd | pc_wake);
    assign csel_next = srst ? `RCPM_CSEL_RESET : (csel_commit ? csel_data[1:0] : csel_reg);

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            pc_reg <= `RCPM_PC_RESET;
            csel_reg <= `RCPM_CSEL_RESET;
        end else begin
            pc_reg <= pc_next;
            csel_reg <= csel_next;
        end
    end

    // ----------------------------------------------------------------
    // power mode gating
    // ----------------------------------------------------------------
    // a lower domain stays up while any higher one is on
    wire core_on = pc_reg[`RCPM_PC_CORE];
    wire periph_on = pc_reg[`RCPM_PC_PERIPH] | core_on;
    wire pll_on = pc_reg[`RCPM_PC_PLL] | periph_on;
    wire xtal_on = pc_reg[`RCPM_PC_XTAL] | pll_on;
    wire [3:0] mode_code = {xtal_on, pll_on, periph_on, core_on};
    wire ref_ext = (csel_reg == `RCPM_CSEL_EXTERNAL);
    logic div_tick;

    // core clock strobe only runs while the pll does
    rcpm_core_div u_core_div (
        .clock(clock),
        .rst_n(rst_sync_n),
        .srst(srst),
        .tick_in(pll_system_clock_tick & pll_on),
        .div_sel(pc_reg[2:0]),
        .tick_out(div_tick)
    );

    always_ff @(posedge clock or negedge rst_sync_n) begin
        if (!rst_sync_n) begin
            core_clock_tick <= 1'b0;
            core_enable <= 1'b1;
            periph_enable <= 1'b1;
            pll_enable <= 1'b1;
            xtal_enable <= 1'b1;
            pll_ref_external <= 1'b0;
            ext_irq_enable <= 1'b1;
            power_mode <= PM_ACTIVE;
        end else begin
            core_clock_tick <= div_tick & core_on;
            core_enable <= core_on;
            periph_enable <= periph_on;
            pll_enable <= pll_on;
            xtal_enable <= xtal_on;
            pll_ref_external <= ref_ext & xtal_on;
            ext_irq_enable <= 1'b1;
            power_mode <= mode_code;
        end
    end

    // ----------------------------------------------------------------
    // assertions
    // ----------------------------------------------------------------
    sequence sw_write_s;
        flags_wr && pwdata[`RCPM_FLAG_SW];
    endsequence

    sequence sw_reset_s;
        flags_reg[`RCPM_FLAG_SW] && !sys_reset_n ##1 !sys_reset_n;
    endsequence

    por_flag_a: assert property (@(posedge clock)
        rst_sync_n && !$past(rst_sync_n) |-> flags_reg[`RCPM_FLAG_POR] && !sys_reset_n)
        else $error("por flag not set after power-on");

    wdt_flag_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
        wdt_timeout |=> flags_reg[`RCPM_FLAG_WDT] ##1 !sys_reset_n)
        else $error("watchdog timeout not recorded");

    ext_flag_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
        !ext_reset_n |=> flags_reg[`RCPM_FLAG_EXT] && !sys_reset_n)
        else $error("external reset not recorded");

    sw_reset_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
        sw_write_s |=> sw_reset_s)
        else $error("software reset not raised");

    clear_bit_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
        clear_wr && pwdata[`RCPM_FLAG_WDT] && !wdt_timeout |=> !flags_reg[`RCPM_FLAG_WDT])
        else $error("clear write did not clear flag");

    unused_zero_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
        setup_phase && !pwrite && sel_flags |=> prdata[31:4] == 28'h0000000)
        else $error("unused flag bits read non-zero");

    clear_resw_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
        clear_wr && flags_reg[`RCPM_FLAG_SW] && !pwdata[`RCPM_FLAG_SW]
        |=> flags_reg[`RCPM_FLAG_SW] ##1 !sys_reset_n)
        else $error("clear without sw bit did not reset");

    wdt_por_only_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
        $fell(sys_reset_n) |-> wdt_reset_n ##1 (pc_reg == `RCPM_PC_RESET))
        else $error("non-por reset hit watchdog or left registers");

    hold_time_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
        hw_req ##1 !hw_req [*8] |-> !sys_reset_n)
        else $error("reset released too early");

    div_default_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
        $rose(sys_reset_n) |-> pc_reg[2:0] == 3'h3)
        else $error("divider default wrong");

    key_guard_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
        pc_reg != $past(pc_reg) |-> $past(pow_commit) || $past(wake_event) || $past(srst))
        else $error("power control changed without key sequence");

    cumulative_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
        core_enable |-> periph_enable && pll_enable && xtal_enable && ext_irq_enable)
        else $error("power domain gating not cumulative");

    wake_set_a: assert property (@(posedge clock) disable iff (!rst_sync_n || srst)
        wake_event |=> pc_reg[5:3] == 3'h7 ##1 core_enable)
        else $error("wake-up did not restore active");

    flag_quiet_a: assert property (@(posedge clock) disable iff (!rst_sync_n)
        flags_wr && !pwdata[`RCPM_FLAG_SW] && !wdt_timeout && ext_reset_n
        |=> flags_reg == $past(flags_reg) && hold_cnt_reg == 8'(($past(hold_cnt_reg) == 8'h00) ? 8'h00
            : ($past(hold_cnt_reg) - 8'h01)))
        else $error("flag write without sw bit had effect");

endmodule // rcpm_top

// ==== dv/rcpm_top_tb.sv ====
// self-checking testbench for the reset, clock and power manager
`timescale 1ns/1ps
`include "rcpm_regs.svh"
module rcpm_top_tb import rcpm_pkg::*;;
    // --------------------------------------------------------------
    // design ports and bench state
    // --------------------------------------------------------------
    logic clock, rstn, psel, penable, pwrite, pready, pslverr;
    logic [31:0] paddr, pwdata, prdata;
    logic wdt_timeout, ext_reset_n, wake_event;
    logic pll_system_clock_tick = 1'b0;
    logic sys_reset_n, wdt_reset_n, boot_kernel_start, core_clock_tick;
    logic core_enable, periph_enable, pll_enable, xtal_enable, pll_ref_external, ext_irq_enable;
    logic [3:0] power_mode;
    logic [31:0] last_rd;
    logic last_err;
    logic por_over = 1'b0;
    logic wdt_seen_low = 1'b0;
    int n_errors = 0;
    int n_compared = 0;
    int n_boot = 0;
    int n_boot_exp = 0;
    int cycles = 0;
    int n;
    logic [3:0] modes [5] = '{4'hf, 4'he, 4'hc, 4'h8, 4'h0};

`define CHK(got, exp) begin n_compared++; if ((got) !== (exp)) begin n_errors++; \
    $display("unexpected at %0t: got %h expected %h", $time, got, exp); end end

    rcpm_top i_rcpm_top (.clock(clock), .rstn(rstn), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .wdt_timeout(wdt_timeout), .ext_reset_n(ext_reset_n), .wake_event(wake_event),
        .pll_system_clock_tick(pll_system_clock_tick), .sys_reset_n(sys_reset_n), .wdt_reset_n(wdt_reset_n),
        .boot_kernel_start(boot_kernel_start), .core_clock_tick(core_clock_tick),
        .core_enable(core_enable), .periph_enable(periph_enable), .pll_enable(pll_enable),
        .xtal_enable(xtal_enable), .pll_ref_external(pll_ref_external),
        .ext_irq_enable(ext_irq_enable), .power_mode(power_mode));

    // --------------------------------------------------------------
    // clock, monitors and hang guard
    // --------------------------------------------------------------
    initial begin
        clock = 1'b0;
        forever #4 clock = ~clock;
    end

    always @(posedge clock) begin
        // pll strobe on every other cycle, so divider counts ticks, not clocks
        pll_system_clock_tick <= ~pll_system_clock_tick;
        if (boot_kernel_start === 1'b1) n_boot++;
        if (por_over && wdt_reset_n !== 1'b1) wdt_seen_low <= 1'b1;
        cycles++;
        if (cycles == 20000) begin
            n_errors++;
            tally_and_finish();
        end
    end

    // --------------------------------------------------------------
    // tasks
    // --------------------------------------------------------------
    task automatic tally_and_finish();
        $display("compared %0d, mismatches %0d", n_compared, n_errors);
        if (n_errors == 0 && n_compared > 0) $display("Finished cleanly");
        else $display("Finished with errors");
        $finish;
    endtask

    // apb transfer; request held until pready is seen high
    task automatic xfer(input logic w, input logic [31:0] a, input logic [31:0] d);
        int k;
        @(posedge clock);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= w;
        paddr <= a;
        pwdata <= d;
        @(posedge clock);
        penable <= 1'b1;
        k = 0;
        do begin
            @(posedge clock);
            k++;
        end while (pready !== 1'b1 && k < 16);
        if (k >= 16) n_errors++;
        last_rd = prdata;
        last_err = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    task automatic chk_rd(input logic [31:0] a, input logic [31:0] e);
        xfer(1'b0, a, 32'h0);
        `CHK(last_rd, e)
        `CHK(last_err, 1'b0)
    endtask

    task automatic keyed(input logic [31:0] k1a, input logic [7:0] k1, input logic [31:0] ta,
                         input logic [7:0] v, input logic [31:0] k2a, input logic [7:0] k2);
        xfer(1'b1, k1a, {24'h0, k1});
        xfer(1'b1, ta, {24'h0, v});
        xfer(1'b1, k2a, {24'h0, k2});
        repeat (3) @(posedge clock);
    endtask

    task automatic pwr(input logic [7:0] v);
        keyed(`RCPM_ADDR_PKEY1, `RCPM_PKEY1_VAL, `RCPM_ADDR_PCTRL, v, `RCPM_ADDR_PKEY2, `RCPM_PKEY2_VAL);
    endtask

    // bounded wait for an internal reset to fall and be released, then the boot pulse
    task automatic wait_rst();
        int k;
        k = 0;
        while (sys_reset_n !== 1'b0 && k < 8) begin
            @(posedge clock);
            k++;
        end
        while (sys_reset_n !== 1'b1 && k < 80) begin
            @(posedge clock);
            k++;
        end
        repeat (3) @(posedge clock);
        n_boot_exp++;
        `CHK(sys_reset_n, 1'b1)
        `CHK(n_boot, n_boot_exp)
    endtask

    task automatic ticks(output int c);
        c = 0;
        repeat (64) begin
            @(posedge clock);
            if (core_clock_tick === 1'b1) c++;
        end
    endtask

    // --------------------------------------------------------------
    // test sequence
    // --------------------------------------------------------------
    initial begin
        rstn = 1'b0;
        psel = 1'b0;
        penable = 1'b0;
        pwrite = 1'b0;
        paddr = 32'h0;
        pwdata = 32'h0;
        wdt_timeout = 1'b0;
        ext_reset_n = 1'b1;
        wake_event = 1'b0;
        repeat (12) @(posedge clock);
        rstn <= 1'b1;
        wait_rst();
        por_over = 1'b1;
        chk_rd(`RCPM_ADDR_FLAGS, 32'h1);
        chk_rd(`RCPM_ADDR_PCTRL, 32'h7b);
        chk_rd(`RCPM_ADDR_CSEL, 32'h0);
        `CHK(pll_ref_external, 1'b0)
        `CHK(power_mode, 4'hf)
        ticks(n);
        `CHK(n, 4)
        $display("test power-on done");

        xfer(1'b1, `RCPM_ADDR_CLEAR, 32'h1);
        chk_rd(`RCPM_ADDR_FLAGS, 32'h0);
        chk_rd(`RCPM_ADDR_CLEAR, 32'h0);
        xfer(1'b0, 32'hffff0238, 32'h0);
        `CHK(last_err, 1'b1)
        xfer(1'b1, `RCPM_ADDR_PCTRL, 32'h78);
        chk_rd(`RCPM_ADDR_PCTRL, 32'h7b);
        keyed(`RCPM_ADDR_PKEY1, 8'h01, `RCPM_ADDR_PCTRL, 8'h78, `RCPM_ADDR_PKEY2, 8'h00);
        chk_rd(`RCPM_ADDR_PCTRL, 32'h7b);
        $display("test clear and keys done");

        for (int i = 0; i < 5; i++) begin
            pwr({1'b0, modes[i], 3'h0});
            `CHK(power_mode, modes[i])
            `CHK(({xtal_enable, pll_enable, periph_enable, core_enable}), modes[i])
            `CHK(ext_irq_enable, 1'b1)
            ticks(n);
            `CHK(n, modes[i][0] ? 32 : 0)
        end
        pwr(8'h40);
        @(posedge clock);
        wake_event <= 1'b1;
        @(posedge clock);
        wake_event <= 1'b0;
        repeat (3) @(posedge clock);
        `CHK(power_mode, 4'hf)
        chk_rd(`RCPM_ADDR_PCTRL, 32'h78);
        keyed(`RCPM_ADDR_CKEY1, `RCPM_CKEY1_VAL, `RCPM_ADDR_CSEL, 8'h02, `RCPM_ADDR_CKEY2, `RCPM_CKEY2_VAL);
        `CHK(pll_ref_external, 1'b1)
        $display("test modes done");

        xfer(1'b1, `RCPM_ADDR_FLAGS, 32'h4);
        wait_rst();
        chk_rd(`RCPM_ADDR_FLAGS, 32'h4);
        chk_rd(`RCPM_ADDR_PCTRL, 32'h7b);
        chk_rd(`RCPM_ADDR_CSEL, 32'h0);
        xfer(1'b1, `RCPM_ADDR_CLEAR, 32'h1);
        wait_rst();
        chk_rd(`RCPM_ADDR_FLAGS, 32'h4);
        xfer(1'b1, `RCPM_ADDR_CLEAR, 32'h4);
        xfer(1'b1, `RCPM_ADDR_FLAGS, 32'hfb);
        repeat (30) @(posedge clock);
        `CHK(n_boot, n_boot_exp)
        chk_rd(`RCPM_ADDR_FLAGS, 32'h0);
        $display("test software reset done");

        @(posedge clock);
        wdt_timeout <= 1'b1;
        @(posedge clock);
        wdt_timeout <= 1'b0;
        wait_rst();
        chk_rd(`RCPM_ADDR_FLAGS, 32'h2);
        xfer(1'b1, `RCPM_ADDR_CLEAR, 32'h2);
        ext_reset_n <= 1'b0;
        repeat (4) @(posedge clock);
        ext_reset_n <= 1'b1;
        wait_rst();
        chk_rd(`RCPM_ADDR_FLAGS, 32'h8);
        `CHK(wdt_seen_low, 1'b0)
        $display("test watchdog and pin done");
        tally_and_finish();
    end
endmodule // rcpm_top_tb
